// ### design/scu_map.vh
`ifndef SCU_MAP_VH
`define SCU_MAP_VH

// Special function register addresses
`define SCU_ADDR_SERIAL_PORT_CONTROL 8'h98
`define SCU_ADDR_SERIAL_BUFFER 8'h99
`define SCU_ADDR_POWER_CONTROL_REG 8'h87

// Control register and power control register field positions
`define SCU_B_SM0 7
`define SCU_B_SM1 6
`define SCU_B_SM2 5
`define SCU_B_REN 4
`define SCU_B_TB8 3
`define SCU_B_RB8 2
`define SCU_B_TI 1
`define SCU_B_RI 0
`define SCU_B_BAUD_DOUBLER 7

// Reset values
`define SCU_SERIAL_PORT_CONTROL_RST 8'h00
`define SCU_BYTE_ZERO 8'h00
`define SCU_POWER_CONTROL_REG_LOW 7'h00

// Mode encodings of the two mode select bits
`define SCU_MODE0 2'b00
`define SCU_MODE1 2'b01
`define SCU_MODE2 2'b10
`define SCU_MODE3 2'b11

// Shift register mode timing: six clocks per bit
`define SCU_M0_PH_LAST 3'h5
`define SCU_M0_PH_HIGH 3'h3
`define SCU_M0_PH_SAMPLE 3'h2
`define SCU_M0_BIT_LAST 4'h7

// Asynchronous timing in sixteenths of a bit
`define SCU_DIV_LAST 4'hf
`define SCU_RX_SMP1 4'h7
`define SCU_RX_SMP3 4'h9
`define SCU_RX_DECIDE 4'ha

// Bit indices inside a frame, start bit is index 0
`define SCU_NINTH_IDX 4'h9
`define SCU_LAST_10 4'h9
`define SCU_LAST_11 4'ha
`define SCU_DATA_LAST 4'h8

`endif

// ### design/scu_vote.v
`timescale 1ns/1ps
`include "scu_map.vh"

// Two out of three majority filter for received line samples
module scu_vote (
    input wire clock,
    input wire rst_b,
    input wire smp_en,
    input wire smp_last,
    input wire bit_in,
    output reg vote_ff
);

reg [1:0] hist_ff;

// Keep the last two samples, decide on the third
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        hist_ff <= 2'b11;
        vote_ff <= 1'b1;
    end else if (smp_en) begin
        hist_ff <= {hist_ff[0], bit_in};
        if (smp_last) begin
            vote_ff <= (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & bit_in) |
                       (hist_ff[0] & bit_in);
        end
    end
end

endmodule

// ### design/scu_uart.v
`timescale 1ns/1ps
`include "scu_map.vh"

// How it works
// - Reset clears whole control register to zero
// - Top two control bits select mode
// - 9-bit filter: ninth bit zero sets no flag
// - 8-bit filter: flag only with valid stop
// - Filter enable ignored in shift mode
// - Receiver starts only while receive enable set; mode 0 byte completes if cleared
// - Ninth transmitted bit comes from tb8_ff
// - rb8_ff holds ninth or stop bit
// - Tx flag set at 8th bit/stop start
// - Rx flag set at 8th bit/mid stop
// - Buffer write starts transmission in every mode
// - Shift mode receives when flag clear, enabled
// - Async receive starts on start bit, enabled
// - Shift mode bit rate is clock/6
// - Mode 2 rate clock/32, doubled gives /16
// - Doubler is bit 7 at address 87h
// - Modes 1,3 rate from timer or generator
// - Timer rate times doubler factor (1 or 2) over 32
// - Auto-reload timer gives documented rate formula
// - Buffer write loads tx, read returns rx
// - Receive buffered; unread byte loses next byte
// - 8-bit frame: start, eight LSB first, stop
// - 9-bit frame adds ninth bit; stop ignored
module scu_uart (
    input wire clock,
    input wire rst_b,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata_ff,
    input wire t1_ovf,
    input wire brg_sel,
    input wire brg_tick,
    input wire rxd_in,
    output reg rxd_out_ff,
    output reg rxd_oe_ff,
    output reg txd_out_ff
);

// Control register fields
reg [1:0] mode_ff;
reg sm2_ff, ren_ff, tb8_ff, rb8_ff;
reg ti_ff, ri_ff, baud_doubler_ff;
reg [7:0] rx_buf_ff;

// Line synchroniser and start edge history
reg rxd_s1_ff, rxd_s2_ff, rxd_prev_ff;

// Sixteen times bit rate tick generation
reg half_ff;
wire rate_src, tick16;

// Asynchronous transmitter
reg tx_req_ff, tx_busy_ff, txd_ff;
reg [3:0] tx_div_ff, tx_cnt_ff;
reg [10:0] tx_sh_ff;

// Asynchronous receiver
reg rx_busy_ff, rx_nin_ff;
reg [3:0] rx_div_ff, rx_cnt_ff;
reg [7:0] rx_sh_ff;
wire rx_vote;

// Shift register mode engine
reg m0_active_ff, m0_dir_tx_ff, m0_clk_ff;
reg [2:0] m0_ph_ff;
reg [3:0] m0_cnt_ff;
reg [7:0] m0_sh_ff;

// Events towards the control register, decodes and timing strobes
reg set_ti, set_ri, rx_load, rx_load_nin;
reg [7:0] rx_load_data;
wire is_m0, is_m1;
wire wr_serial_port_control, wr_serial_buffer, wr_power_control_reg;
wire tx_roll, rx_fall, rx_decide, rx_smp_en;
wire [3:0] tx_last, rx_last;

// Mode decode from the top two control bits
assign is_m0 = (mode_ff == `SCU_MODE0);
assign is_m1 = (mode_ff == `SCU_MODE1);

// Register write decode
assign wr_serial_port_control = sfr_wr && (sfr_addr == `SCU_ADDR_SERIAL_PORT_CONTROL);
assign wr_serial_buffer = sfr_wr && (sfr_addr == `SCU_ADDR_SERIAL_BUFFER);
assign wr_power_control_reg = sfr_wr && (sfr_addr == `SCU_ADDR_POWER_CONTROL_REG);

// Mode 2 runs from the clock, modes 1 and 3 from timer or generator
assign rate_src = (mode_ff == `SCU_MODE2) ? 1'b1 :
                  (brg_sel ? brg_tick : t1_ovf);
// Undoubled rate halves the source; sixteen ticks make one bit
assign tick16 = rate_src & (baud_doubler_ff | half_ff);

// Halving toggle for the undoubled rates
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        half_ff <= 1'b0;
    end else if (rate_src) begin
        half_ff <= ~half_ff;
    end
end

// Two flip-flop synchroniser on the receive pin
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        rxd_s1_ff <= 1'b1;
        rxd_s2_ff <= 1'b1;
        rxd_prev_ff <= 1'b1;
    end else begin
        rxd_s1_ff <= rxd_in;
        rxd_s2_ff <= rxd_s1_ff;
        if (tick16) begin
            rxd_prev_ff <= rxd_s2_ff;
        end
    end
end

// Control, doubler and receive buffer; hardware sets win over clears
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        mode_ff <= `SCU_MODE0;
        sm2_ff <= 1'b0;
        ren_ff <= 1'b0;
        tb8_ff <= 1'b0;
        rb8_ff <= 1'b0;
        ti_ff <= 1'b0;
        ri_ff <= 1'b0;
        baud_doubler_ff <= 1'b0;
        rx_buf_ff <= `SCU_BYTE_ZERO;
    end else begin
        if (wr_serial_port_control) begin
            mode_ff <= {sfr_wdata[`SCU_B_SM0], sfr_wdata[`SCU_B_SM1]};
            sm2_ff <= sfr_wdata[`SCU_B_SM2];
            ren_ff <= sfr_wdata[`SCU_B_REN];
            tb8_ff <= sfr_wdata[`SCU_B_TB8];
        end
        if (wr_power_control_reg) begin
            baud_doubler_ff <= sfr_wdata[`SCU_B_BAUD_DOUBLER];
        end
        // Flags cleared only by software, set by hardware
        ti_ff <= (wr_serial_port_control ? sfr_wdata[`SCU_B_TI] : ti_ff) | set_ti;
        ri_ff <= (wr_serial_port_control ? sfr_wdata[`SCU_B_RI] : ri_ff) | set_ri;
        if (rx_load && !is_m0) begin
            rb8_ff <= rx_load_nin;
        end else if (wr_serial_port_control) begin
            rb8_ff <= sfr_wdata[`SCU_B_RB8];
        end
        if (rx_load) begin
            rx_buf_ff <= rx_load_data;
        end
    end
end

// Registered read data, unmapped addresses read zero
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        sfr_rdata_ff <= `SCU_BYTE_ZERO;
    end else if (sfr_rd) begin
        if (sfr_addr == `SCU_ADDR_SERIAL_PORT_CONTROL) begin
            sfr_rdata_ff <= {mode_ff, sm2_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};
        end else if (sfr_addr == `SCU_ADDR_SERIAL_BUFFER) begin
            sfr_rdata_ff <= rx_buf_ff;
        end else if (sfr_addr == `SCU_ADDR_POWER_CONTROL_REG) begin
            sfr_rdata_ff <= {baud_doubler_ff, `SCU_POWER_CONTROL_REG_LOW};
        end else begin
            sfr_rdata_ff <= `SCU_BYTE_ZERO;
        end
    end
end

// Transmit bit times follow the free running divide by sixteen
assign tx_roll = tick16 && (tx_div_ff == `SCU_DIV_LAST);
assign tx_last = is_m1 ? `SCU_LAST_10 : `SCU_LAST_11;

// Asynchronous transmitter: start, data LSB first, ninth in modes 2 and 3, stop
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        tx_req_ff <= 1'b0;
        tx_busy_ff <= 1'b0;
        tx_div_ff <= 4'h0;
        tx_cnt_ff <= 4'h0;
        tx_sh_ff <= 11'h7ff;
        txd_ff <= 1'b1;
    end else begin
        if (tick16) begin
            tx_div_ff <= tx_div_ff + 4'h1;
        end
        if (wr_serial_buffer && !is_m0) begin
            // Frame image: stop, ninth or stop, data, start
            tx_sh_ff <= {1'b1, (is_m1 ? 1'b1 : tb8_ff), sfr_wdata, 1'b0};
            tx_req_ff <= 1'b1;
            tx_busy_ff <= 1'b0;
            txd_ff <= 1'b1;
        end else if (tx_roll) begin
            if (tx_req_ff) begin
                tx_req_ff <= 1'b0;
                tx_busy_ff <= 1'b1;
                tx_cnt_ff <= 4'h0;
                txd_ff <= tx_sh_ff[0];
            end else if (tx_busy_ff) begin
                if (tx_cnt_ff == tx_last) begin
                    tx_busy_ff <= 1'b0;
                    txd_ff <= 1'b1;
                end else begin
                    tx_cnt_ff <= tx_cnt_ff + 4'h1;
                    txd_ff <= tx_sh_ff[1];
                    tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                end
            end
        end
    end
end

// Receive sampling points and falling edge on the line
assign rx_fall = rxd_prev_ff && !rxd_s2_ff;
assign rx_smp_en = tick16 && rx_busy_ff && (rx_div_ff >= `SCU_RX_SMP1) &&
                   (rx_div_ff <= `SCU_RX_SMP3);
assign rx_decide = tick16 && rx_busy_ff && (rx_div_ff == `SCU_RX_DECIDE);
assign rx_last = is_m1 ? `SCU_LAST_10 : `SCU_LAST_11;

// Majority of three samples per bit
scu_vote u_vote (
    .clock(clock),
    .rst_b(rst_b),
    .smp_en(rx_smp_en),
    .smp_last(rx_div_ff == `SCU_RX_SMP3),
    .bit_in(rxd_s2_ff),
    .vote_ff(rx_vote)
);

// Asynchronous receiver
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        rx_busy_ff <= 1'b0;
        rx_div_ff <= 4'h0;
        rx_cnt_ff <= 4'h0;
        rx_sh_ff <= `SCU_BYTE_ZERO;
        rx_nin_ff <= 1'b0;
    end else if (!ren_ff || is_m0) begin
        rx_busy_ff <= 1'b0;
    end else if (!rx_busy_ff) begin
        if (tick16 && rx_fall) begin
            rx_busy_ff <= 1'b1;
            rx_div_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
        end
    end else if (tick16) begin
        rx_div_ff <= rx_div_ff + 4'h1;
        if (rx_decide) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == 4'h0 && rx_vote) begin
                rx_busy_ff <= 1'b0; // False start bit rejected
            end else if (rx_cnt_ff == rx_last) begin
                rx_busy_ff <= 1'b0;
            end else if (rx_cnt_ff == `SCU_NINTH_IDX) begin
                rx_nin_ff <= rx_vote;
            end else if (rx_cnt_ff != 4'h0) begin
                rx_sh_ff <= {rx_vote, rx_sh_ff[7:1]};
            end
        end
    end
end

// Shift register mode: tx takes priority, rx waits for a clear flag
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        m0_active_ff <= 1'b0;
        m0_dir_tx_ff <= 1'b0;
        m0_ph_ff <= 3'h0;
        m0_cnt_ff <= 4'h0;
        m0_sh_ff <= `SCU_BYTE_ZERO;
        m0_clk_ff <= 1'b1;
    end else if (!is_m0) begin
        m0_active_ff <= 1'b0;
        m0_clk_ff <= 1'b1;
    end else if (wr_serial_buffer) begin
        m0_active_ff <= 1'b1;
        m0_dir_tx_ff <= 1'b1;
        m0_ph_ff <= 3'h0;
        m0_cnt_ff <= 4'h0;
        m0_sh_ff <= sfr_wdata;
        m0_clk_ff <= 1'b0;
    end else if (!m0_active_ff) begin
        m0_clk_ff <= 1'b1;
        if (ren_ff && !ri_ff) begin
            m0_active_ff <= 1'b1;
            m0_dir_tx_ff <= 1'b0;
            m0_ph_ff <= 3'h0;
            m0_cnt_ff <= 4'h0;
            m0_clk_ff <= 1'b0;
        end
    end else begin
        // Six clocks per bit: clock low three, high three
        m0_clk_ff <= (m0_ph_ff + 3'h1 >= `SCU_M0_PH_HIGH) &&
                     (m0_ph_ff != `SCU_M0_PH_LAST);
        if (m0_ph_ff == `SCU_M0_PH_SAMPLE && !m0_dir_tx_ff) begin
            m0_sh_ff <= {rxd_s2_ff, m0_sh_ff[7:1]};
        end
        if (m0_ph_ff == `SCU_M0_PH_LAST) begin
            m0_ph_ff <= 3'h0;
            m0_cnt_ff <= m0_cnt_ff + 4'h1;
            if (m0_dir_tx_ff) begin
                m0_sh_ff <= {1'b0, m0_sh_ff[7:1]};
            end
            if (m0_cnt_ff == `SCU_M0_BIT_LAST) begin
                m0_active_ff <= 1'b0;
                m0_clk_ff <= 1'b1;
            end
        end else begin
            m0_ph_ff <= m0_ph_ff + 3'h1;
        end
    end
end

// Flag and load events from all engines
always @* begin
    set_ti = 1'b0;
    set_ri = 1'b0;
    rx_load = 1'b0;
    rx_load_data = rx_sh_ff;
    rx_load_nin = rx_nin_ff;
    // Transmit flag at the start of the stop bit
    if (!is_m0 && tx_roll && tx_busy_ff && !tx_req_ff &&
        (tx_cnt_ff + 4'h1 == tx_last)) begin
        set_ti = 1'b1;
    end
    // Shift mode: end of the eighth bit time
    if (is_m0 && m0_active_ff && m0_ph_ff == `SCU_M0_PH_LAST &&
        m0_cnt_ff == `SCU_M0_BIT_LAST && !wr_serial_buffer) begin
        if (m0_dir_tx_ff) begin
            set_ti = 1'b1;
        end else begin
            // Filter bit plays no part here
            set_ri = 1'b1;
            rx_load = 1'b1;
            rx_load_data = m0_sh_ff;
        end
    end
    // Async: decision at the middle of the stop bit
    if (!is_m0 && ren_ff && rx_decide && rx_cnt_ff == rx_last) begin
        rx_load_nin = is_m1 ? rx_vote : rx_nin_ff;
        // Unread previous byte means this frame is dropped
        if (!ri_ff && (!sm2_ff || rx_load_nin)) begin
            set_ri = 1'b1;
            rx_load = 1'b1;
        end
    end
end

// Pin drivers: mode 0 uses the data pin both ways, tx pin as clock
always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
        rxd_out_ff <= 1'b1;
        rxd_oe_ff <= 1'b0;
        txd_out_ff <= 1'b1;
    end else begin
        rxd_oe_ff <= is_m0 && m0_active_ff && m0_dir_tx_ff;
        rxd_out_ff <= m0_sh_ff[0];
        txd_out_ff <= is_m0 ? m0_clk_ff : txd_ff;
    end
end

endmodule

// ### dv/scu_peer.sv
`timescale 1ns/1ps
// Remote serial device: drives the receive line, samples the transmit line
module scu_peer (
    input logic clock,
    input logic txd,
    output logic line
);
    initial line = 1'b1;
    // Sends n bits LSB first, p clocks each, then idles high for one bit time
    task automatic send(input logic [10:0] f, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            line = f[i];
            repeat (p) @(posedge clock);
            #1;
        end
        line = 1'b1;
        // A zero stop bit must not merge with the next start edge
        repeat (p) @(posedge clock);
    endtask
    // Waits for the start edge, then samples each bit in its middle
    task automatic recv(input int n, input int p, output logic [10:0] f);
        int w;
        f = '1;
        w = 0;
        while (txd !== 1'b0 && w < 4000) begin
            @(posedge clock);
            #1 w++;
        end
        repeat (p / 2) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            #1 f[i] = txd;
            repeat (p) @(posedge clock);
        end
    endtask
endmodule

// ### dv/scu_uart_assertions.sv
`timescale 1ns/1ps
`include "scu_map.vh"
// Port-level checks of the serial port block
module scu_uart_assertions (
    input logic clock,
    input logic rst_b,
    input logic [7:0] sfr_addr,
    input logic sfr_wr,
    input logic sfr_rd,
    input logic [7:0] sfr_wdata,
    input logic [7:0] sfr_rdata_ff,
    input logic rxd_oe_ff,
    input logic txd_out_ff
);
    reg [4:0] ctl_ff;
    reg dbl_ff;
    wire [1:0] mode = ctl_ff[4:3];
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Shadow of the software-owned control bits and the doubler
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl_ff <= 5'h00;
            dbl_ff <= 1'b0;
        end else if (sfr_wr) begin
            if (sfr_addr == `SCU_ADDR_SERIAL_PORT_CONTROL) ctl_ff <= sfr_wdata[7:3];
            if (sfr_addr == `SCU_ADDR_POWER_CONTROL_REG) dbl_ff <= sfr_wdata[7];
        end
    end
    // Shift clock low phase, then high
    sequence s_clk_low;
        !txd_out_ff [*3] ##1 txd_out_ff;
    endsequence
    // At least sixteen clocks low
    sequence s_low16;
        !txd_out_ff [*8] ##1 !txd_out_ff [*8];
    endsequence
    a_reset_idle: assert property ($rose(rst_b) |-> !sfr_rdata_ff && txd_out_ff)
        else $error("Outputs not idle after reset");
    a_ctl_readback: assert property (sfr_rd && sfr_addr == `SCU_ADDR_SERIAL_PORT_CONTROL
        |=> sfr_rdata_ff[7:3] == $past(ctl_ff)) else $error("Control readback wrong");
    a_dbl_readback: assert property (sfr_rd && sfr_addr == `SCU_ADDR_POWER_CONTROL_REG
        |=> sfr_rdata_ff == {$past(dbl_ff), 7'h00}) else $error("Doubler readback wrong");
    a_unmapped_zero: assert property (sfr_rd && sfr_addr != `SCU_ADDR_SERIAL_PORT_CONTROL
        && sfr_addr != `SCU_ADDR_SERIAL_BUFFER && sfr_addr != `SCU_ADDR_POWER_CONTROL_REG |=> sfr_rdata_ff == 8'h00)
        else $error("Unmapped read not zero");
    a_m0_clk_low: assert property (mode == `SCU_MODE0 && $fell(txd_out_ff) |-> s_clk_low)
        else $error("Shift clock low phase wrong");
    a_m0_clk_high: assert property (mode == `SCU_MODE0 && $rose(txd_out_ff)
        |-> txd_out_ff [*3]) else $error("Shift clock high phase wrong");
    a_oe_mode0: assert property ($rose(rxd_oe_ff) |-> mode == `SCU_MODE0)
        else $error("Data pin driven outside shift mode");
    a_m2_bit_len: assert property (mode == `SCU_MODE2 && $fell(txd_out_ff) |-> s_low16)
        else $error("Mode 2 bit too short");
endmodule
bind scu_uart scu_uart_assertions u_chk (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff),
    .rxd_oe_ff(rxd_oe_ff), .txd_out_ff(txd_out_ff));

// ### dv/scu_uart_bench.sv
`timescale 1ns/1ps
`include "scu_map.vh"
// Self-checking bench for the serial port block
module scu_uart_bench;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic t1_ovf = 1'b0;
    logic brg_sel = 1'b0;
    logic brg_tick = 1'b0;
    logic peer_line;
    wire [7:0] sfr_rdata_ff;
    wire rxd_out_ff;
    wire rxd_oe_ff;
    wire txd_out_ff;
    wire rxd_pin = rxd_oe_ff ? rxd_out_ff : peer_line;
    int err_total = 0;
    int comparisons = 0;
    int seed = 32'hb585;
    int t1_per = 2;
    int brg_per = 3;
    int t1_cnt = 0;
    int brg_cnt = 0;

    scu_uart u_dut (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff), .t1_ovf(t1_ovf),
        .brg_sel(brg_sel), .brg_tick(brg_tick), .rxd_in(rxd_pin), .rxd_out_ff(rxd_out_ff),
        .rxd_oe_ff(rxd_oe_ff), .txd_out_ff(txd_out_ff));
    scu_peer u_peer (.clock(clock), .txd(txd_out_ff), .line(peer_line));

    initial forever #5 clock = ~clock;
    // Timer overflow and generator pulses, no timer interrupt involved
    always @(posedge clock) begin
        t1_cnt <= (t1_cnt + 1) % t1_per;
        brg_cnt <= (brg_cnt + 1) % brg_per;
        t1_ovf <= #1 (t1_cnt == 0);
        brg_tick <= #1 (brg_cnt == 0);
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clock);
        #1 sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clock);
        #1 sfr_rd = 1'b0;
        d = sfr_rdata_ff;
    endtask
    // Frame bits from index 0: start, data LSB first, ninth or stop, stop
    function automatic logic [10:0] frm(input logic [7:0] d, input logic nb);
        return {1'b1, nb, d, 1'b0};
    endfunction
    // Bit time in clocks for mode, doubler and rate source
    function automatic int bit_len(input logic [1:0] m, input logic dbl, input logic bsel);
        int src;
        src = (m == `SCU_MODE2) ? 1 : (bsel ? brg_per : t1_per);
        return 16 * src * (dbl ? 1 : 2);
    endfunction
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #400_000;
        err_total++;
        summarize();
    end

    initial begin
        logic [7:0] c;
        logic [7:0] g;
        logic [7:0] d;
        logic [10:0] f;
        logic tb8;
        logic nb;
        logic [1:0] m;
        int n;
        int p;
        repeat (5) @(posedge clock);
        #1 rst_b = 1'b1;
        rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
        chk(c, `SCU_SERIAL_PORT_CONTROL_RST);
        rd(`SCU_ADDR_POWER_CONTROL_REG, c);
        chk(c, 8'h00);
        rd(8'h55, c);
        chk(c, 8'h00);
        // Asynchronous modes with both rate sources and both doubler values
        for (int k = 0; k < 4; k++) begin
            m = (k == 0) ? `SCU_MODE1 : ((k == 3) ? `SCU_MODE3 : `SCU_MODE2);
            n = (m == `SCU_MODE1) ? 10 : 11;
            p = bit_len(m, k < 2, k == 3);
            brg_sel = (k == 3);
            d = $random(seed);
            tb8 = d[7];
            wr(`SCU_ADDR_POWER_CONTROL_REG, {k < 2, 7'h00});
            wr(`SCU_ADDR_SERIAL_PORT_CONTROL, {m, 2'b01, tb8, 3'b000});
            d = $random(seed);
            wr(`SCU_ADDR_SERIAL_BUFFER, d);
            u_peer.recv(n, p, f);
            chk(f, frm(d, n == 10 ? 1'b1 : tb8));
            rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
            chk(c, {m, 2'b01, tb8, 3'b010});
            d = $random(seed);
            nb = (n == 10) | d[3];
            u_peer.send(frm(d, nb), n, p);
            rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
            chk(c, {m, 2'b01, tb8, nb, 2'b11});
            u_peer.send(frm(~d, 1'b1), n, p);
            rd(`SCU_ADDR_SERIAL_BUFFER, g);
            chk(g, d);
            wr(`SCU_ADDR_SERIAL_PORT_CONTROL, {m, 2'b11, tb8, 3'b000});
            u_peer.send(frm(d ^ 8'h5a, 1'b0), n, p);
            rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
            chk(c[0], 1'b0);
            u_peer.send(frm(d ^ 8'ha5, 1'b1), n, p);
            rd(`SCU_ADDR_SERIAL_BUFFER, g);
            chk(g, d ^ 8'ha5);
            wr(`SCU_ADDR_SERIAL_PORT_CONTROL, {m, 6'h00});
            u_peer.send(frm(~d, 1'b1), n, p);
            rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
            chk(c, {m, 6'h00});
        end
        // Shift register mode, transmit then receive
        wr(`SCU_ADDR_SERIAL_PORT_CONTROL, 8'h00);
        d = $random(seed);
        wr(`SCU_ADDR_SERIAL_BUFFER, d);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_out_ff);
            #1 g[i] = rxd_out_ff;
            chk(rxd_oe_ff, 1'b1);
        end
        chk(g, d);
        repeat (8) @(posedge clock);
        rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
        chk(c, 8'h02);
        chk(rxd_oe_ff, 1'b0);
        d = $random(seed);
        u_peer.line = d[0];
        wr(`SCU_ADDR_SERIAL_PORT_CONTROL, 8'h30);
        for (int i = 1; i < 8; i++) begin
            @(posedge txd_out_ff);
            #1 u_peer.line = d[i];
        end
        repeat (20) @(posedge clock);
        rd(`SCU_ADDR_SERIAL_PORT_CONTROL, c);
        chk(c, 8'h31);
        rd(`SCU_ADDR_SERIAL_BUFFER, g);
        chk(g, d);
        // No new shift clock while the flag stays set
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            #1 chk(txd_out_ff, 1'b1);
        end
        summarize();
    end
endmodule
